/* core/gbs_gpio_bank.sv */
// GPIO bank of ten pads with a network-status indicator on pad 0.
`timescale 1ns/1ps
module gbs_gpio_bank
  import gbs_pkg::*;
#(
  parameter int ON_CYC  = BLINK_ON_CYC,
  parameter int OFF_CYC = BLINK_OFF_CYC
)
(
  // Clock, reset and enable
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                clk_en,
  // Pad input levels
  input  wire logic [NUM_PADS-1:0] pad_i,
  // Configuration
  input  wire logic [NUM_PADS-1:0] cfg_dir_wr,
  input  wire logic [NUM_PADS-1:0] cfg_dir,
  input  wire logic                cfg_alt_wr,
  input  wire logic                cfg_alt,
  // User access
  input  wire logic                wr_en,
  input  wire logic [NUM_PADS-1:0] wr_mask,
  input  wire logic [NUM_PADS-1:0] wr_data,
  input  wire logic                rd_en,
  // Network state from firmware
  input  wire gbs_net_type         net_state,
  input  wire logic                wake_evt,
  // Pad outputs, read-back and alternate-function status
  output logic [NUM_PADS-1:0]      pad_o,
  output logic [NUM_PADS-1:0]      pad_oe,
  output logic [NUM_PADS-1:0]      pull_en,
  output logic [NUM_PADS-1:0]      rd_data,
  output logic                     rd_valid,
  output logic                     alt_active
);

  // All state sits in one word so that reset and clock enable treat every flop alike.
  typedef struct packed {
    logic [NUM_PADS-1:0] sync1;
    logic [NUM_PADS-1:0] sync2;
    logic [NUM_PADS-1:0] dir;
    logic [NUM_PADS-1:0] out;
    logic                alt;
    gbs_pins_type        pins;
    logic [CNT_W-1:0]    cnt;
    gbs_phase_type       phase;
    logic                led;
  } gbs_state_type;

  gbs_state_type st_ff;
  gbs_state_type nxt_st_ff;

  localparam logic [CNT_W-1:0] ON_LAST  = CNT_W'(ON_CYC - 1);
  localparam logic [CNT_W-1:0] OFF_LAST = CNT_W'(OFF_CYC - 1);

  // One step of the interval timer shared by the blink phases and the wake-up pulse.
  function automatic logic [CNT_W-1:0] timer_next(
    input logic [CNT_W-1:0] cnt
  );
    return cnt + 1'b1;
  endfunction

  // Greater-or-equal rather than equal, so a count left over from another state still ends its interval.
  function automatic logic timer_done(
    input logic [CNT_W-1:0] cnt,
    input logic [CNT_W-1:0] last
  );
    return cnt >= last;
  endfunction

  // Pads open to user reads and writes; pad 0 drops out while the indicator owns it.
  function automatic logic [NUM_PADS-1:0] user_mask(
    input logic alt
  );
    return {{(NUM_PADS-1){1'b1}}, ~alt};
  endfunction

  // Replaces the masked bits of a word and keeps the others.
  function automatic logic [NUM_PADS-1:0] merge_bits(
    input logic [NUM_PADS-1:0] old_bits,
    input logic [NUM_PADS-1:0] new_bits,
    input logic [NUM_PADS-1:0] mask
  );
    return (old_bits & ~mask) | (new_bits & mask);
  endfunction

  // Output pads read back the written level, input pads the synchronised pad level.
  function automatic logic [NUM_PADS-1:0] read_word(
    input logic [NUM_PADS-1:0] out_bits,
    input logic [NUM_PADS-1:0] sync_bits,
    input logic [NUM_PADS-1:0] dir_bits,
    input logic [NUM_PADS-1:0] mask
  );
    return ((out_bits & dir_bits) | (sync_bits & ~dir_bits)) & mask;
  endfunction

  always_comb
  begin
    logic [NUM_PADS-1:0] drv;
    logic [NUM_PADS-1:0] oe;
    logic [NUM_PADS-1:0] sel_mask;
    drv = '0;
    oe = '0;
    sel_mask = '0;
    nxt_st_ff = st_ff;
    nxt_st_ff.pins.rd_valid = 1'b0;
    // Only the second stage is read; the first may still be settling.
    nxt_st_ff.sync1 = pad_i; // R9
    nxt_st_ff.sync2 = st_ff.sync1; // R9
    for (int i = 0; i < NUM_PADS; i++)
    begin
      if (cfg_dir_wr[i])
      begin
        nxt_st_ff.dir[i] = cfg_dir[i];
      end
    end
    if (cfg_alt_wr)
    begin
      nxt_st_ff.alt = cfg_alt; // R6
    end
    sel_mask = user_mask(st_ff.alt); // R5
    if (wr_en)
    begin
      // Writes to input pads are dropped so a later direction change starts from the old level.
      nxt_st_ff.out = merge_bits(st_ff.out, wr_data, wr_mask & st_ff.dir & sel_mask); // R3 R5
    end
    if (rd_en)
    begin
      nxt_st_ff.pins.rd_data = read_word(st_ff.out, st_ff.sync2, st_ff.dir, sel_mask); // R2 R3 R5
      nxt_st_ff.pins.rd_valid = 1'b1;
    end
    // Blink timer; it restarts in the off, not-registered and unknown states, while power saving parks it in the off phase.
    case (net_state)
      GBS_OFF:
      begin
        nxt_st_ff.led = 1'b0; // R7
        nxt_st_ff.cnt = '0;
        nxt_st_ff.phase = GBS_PH_ON;
      end
      GBS_NOT_REG:
      begin
        nxt_st_ff.led = 1'b1; // R7
        nxt_st_ff.cnt = '0;
        nxt_st_ff.phase = GBS_PH_ON;
      end
      GBS_REG_IDLE, GBS_CONNECTING:
      begin
        nxt_st_ff.led = (st_ff.phase == GBS_PH_ON); // R7
        nxt_st_ff.cnt = timer_next(st_ff.cnt); // R9
        if (st_ff.phase == GBS_PH_ON && timer_done(st_ff.cnt, ON_LAST))
        begin
          nxt_st_ff.cnt = '0;
          nxt_st_ff.phase = GBS_PH_OFF;
        end
        else if (st_ff.phase == GBS_PH_OFF && timer_done(st_ff.cnt, OFF_LAST))
        begin
          nxt_st_ff.cnt = '0;
          nxt_st_ff.phase = GBS_PH_ON;
        end
      end
      GBS_REG_PSM:
      begin
        // One pulse of the on time per wake-up; a new wake restarts it.
        nxt_st_ff.phase = GBS_PH_OFF;
        if (wake_evt)
        begin
          nxt_st_ff.led = 1'b1; // R8
          nxt_st_ff.cnt = '0;
        end
        else if (st_ff.led)
        begin
          nxt_st_ff.cnt = timer_next(st_ff.cnt);
          if (timer_done(st_ff.cnt, ON_LAST))
          begin
            nxt_st_ff.led = 1'b0; // R8
            nxt_st_ff.cnt = '0;
          end
        end
      end
      default:
      begin
        nxt_st_ff.led = 1'b0;
        nxt_st_ff.cnt = '0;
        nxt_st_ff.phase = GBS_PH_ON;
      end
    endcase
    // Pins follow the next state, so every output is a plain flop with no logic behind it.
    drv = nxt_st_ff.out;
    oe = nxt_st_ff.dir; // R4
    if (nxt_st_ff.alt)
    begin
      drv[0] = nxt_st_ff.led; // R6
      oe[0] = 1'b1; // R5
    end
    nxt_st_ff.pins.pad_o = drv;
    nxt_st_ff.pins.pad_oe = oe;
    nxt_st_ff.pins.pull_en = ~oe; // R1
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_ff <= '{sync1: '0, sync2: '0, dir: RST_DIR, out: RST_OUT, alt: 1'b0,
                 pins: '{pad_o: RST_OUT, pad_oe: RST_DIR, pull_en: RST_PULL, rd_data: '0, rd_valid: 1'b0},
                 cnt: '0, phase: GBS_PH_ON, led: 1'b0}; // R1
    end
    // A low clock enable holds every flop, the synchroniser included.
    else if (clk_en)
    begin
      st_ff <= nxt_st_ff;
    end
  end

  assign pad_o = st_ff.pins.pad_o;
  assign pad_oe = st_ff.pins.pad_oe;
  assign pull_en = st_ff.pins.pull_en;
  assign rd_data = st_ff.pins.rd_data;
  assign rd_valid = st_ff.pins.rd_valid;
  assign alt_active = st_ff.alt;

endmodule

/* core/gbs_pkg.sv */
// Package with constants and types for the GPIO bank with status indicator.
// Functional notes
// R1 - Ten two-way pads come out of reset as inputs with the weak pull-down enabled.
// R2 - An input pad is read only and a read returns the level present on the pad.
// R3 - An output pad takes writes of its level and a query returns the last level written.
// R4 - An output pad is driven push-pull, high and low alike.
// R5 - A pad in its alternate function is driven by firmware logic and ignores user reads and writes.
// R6 - The network-status indicator appears only on pad 0, and only once its alternate function is selected.
// R7 - The indicator is off when the device is off, on when not registered, and blinks one second on, two off when idle or connecting.
// R8 - In registered idle with power saving the indicator pulses once per wake-up event.
// R9 - Input levels pass a two-stage synchroniser and blink intervals are timed by a counter on the system clock.
package gbs_pkg;
  localparam int NUM_PADS = 10;
  localparam int CLK_HZ = 125000000;
  localparam int BLINK_ON_S = 1;
  localparam int BLINK_OFF_S = 2;
  localparam int BLINK_ON_CYC = BLINK_ON_S * CLK_HZ;
  localparam int BLINK_OFF_CYC = BLINK_OFF_S * CLK_HZ;
  localparam int CNT_W = 29;
  localparam logic [NUM_PADS-1:0] RST_DIR = 10'h000;
  localparam logic [NUM_PADS-1:0] RST_OUT = 10'h000;
  localparam logic [NUM_PADS-1:0] RST_PULL = 10'h3ff;

  typedef enum logic [2:0] {
    GBS_OFF,
    GBS_NOT_REG,
    GBS_REG_IDLE,
    GBS_REG_PSM,
    GBS_CONNECTING
  } gbs_net_type;

  typedef enum {
    GBS_PH_ON,
    GBS_PH_OFF
  } gbs_phase_type;

  typedef struct packed {
    logic [NUM_PADS-1:0] pad_o;
    logic [NUM_PADS-1:0] pad_oe;
    logic [NUM_PADS-1:0] pull_en;
    logic [NUM_PADS-1:0] rd_data;
    logic                rd_valid;
  } gbs_pins_type;
endpackage

/* tb/gbs_gpio_bank_asserts.sv */
// Checker on the ports of the GPIO bank.
`timescale 1ns/1ps
module gbs_gpio_bank_chk
  import gbs_pkg::*;
(
  // Clock, reset and requests
  input wire logic                clk,
  input wire logic                nrst,
  input wire logic                clk_en,
  input wire logic [NUM_PADS-1:0] cfg_dir_wr,
  input wire logic [NUM_PADS-1:0] cfg_dir,
  input wire logic                cfg_alt_wr,
  input wire logic                cfg_alt,
  input wire logic                wr_en,
  input wire logic [NUM_PADS-1:0] wr_mask,
  input wire logic [NUM_PADS-1:0] wr_data,
  input wire logic                rd_en,
  input wire gbs_net_type         net_state,
  // Design outputs
  input wire logic [NUM_PADS-1:0] pad_o,
  input wire logic [NUM_PADS-1:0] pad_oe,
  input wire logic [NUM_PADS-1:0] pull_en,
  input wire logic                rd_valid,
  input wire logic                alt_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  pull_follows_dir_a: assert property (pull_en == ~pad_oe) else $error("pull-down not the inverse of drive");
  read_answer_a: assert property (clk_en && rd_en |=> rd_valid) else $error("read not answered");
  read_pulse_a: assert property (clk_en && !rd_en |=> !rd_valid) else $error("read strobe without request");
  write_level_a: assert property (clk_en && wr_en |=> ((pad_o ^ $past(wr_data))
    & $past(wr_mask & pad_oe & ~cfg_dir_wr) & 10'h3fe) == 10'h000) else $error("written level lost");
  dir_update_a: assert property (clk_en && cfg_dir_wr != 10'h000 |=> ((pad_oe ^ $past(cfg_dir))
    & $past(cfg_dir_wr) & 10'h3fe) == 10'h000) else $error("direction not taken");
  alt_drives_a: assert property (alt_active |-> pad_oe[0]) else $error("indicator pad not driven");
  alt_select_a: assert property (clk_en && cfg_alt_wr |=> alt_active == $past(cfg_alt)) else $error("alt select lost");
  led_steady_a: assert property (alt_active && clk_en && net_state == GBS_NOT_REG |=> pad_o[0] || !alt_active)
    else $error("indicator not on while unregistered");
  led_off_a: assert property (alt_active && clk_en && net_state == GBS_OFF |=> !pad_o[0] || !alt_active)
    else $error("indicator lit while device off");
endmodule
bind gbs_gpio_bank gbs_gpio_bank_chk chk_u (.clk, .nrst, .clk_en, .cfg_dir_wr, .cfg_dir, .cfg_alt_wr, .cfg_alt,
  .wr_en, .wr_mask, .wr_data, .rd_en, .net_state, .pad_o, .pad_oe, .pull_en, .rd_valid, .alt_active);

/* tb/gbs_pad_model.sv */
// Model of the far-side devices and pull resistors on the ten pads.
`timescale 1ns/1ps
module gbs_pad_model
  import gbs_pkg::*;
(
  // Design drive and far-side drive
  input  wire logic [NUM_PADS-1:0] pad_o,
  input  wire logic [NUM_PADS-1:0] pad_oe,
  input  wire logic [NUM_PADS-1:0] pull_en,
  input  wire logic [NUM_PADS-1:0] ext_en,
  input  wire logic [NUM_PADS-1:0] ext_lvl,
  output logic      [NUM_PADS-1:0] pad_w
);
  // A pad with no driver and no pull floats, so it shows the inverse of the drive level instead of a clean 0.
  assign pad_w = (pad_oe & pad_o) | (~pad_oe & ext_en & ext_lvl) | (~pad_oe & ~ext_en & ~pull_en & ~pad_o);
endmodule

/* tb/testbench.sv */
// Self-checking bench for the GPIO bank with status indicator.
`timescale 1ns/1ps
module testbench;
  import gbs_pkg::*;
  logic clk = 1'h0, nrst = 1'h0, clk_en = 1'h1, cfg_alt_wr = 1'h0, cfg_alt = 1'h0;
  logic wr_en = 1'h0, rd_en = 1'h0, wake_evt = 1'h0, rd_valid, alt_active;
  logic [NUM_PADS-1:0] cfg_dir_wr = 10'h0, cfg_dir = 10'h0, wr_mask = 10'h0, wr_data = 10'h0;
  logic [NUM_PADS-1:0] ext_en = 10'h0, ext_lvl = 10'h0, pad_w, pad_o, pad_oe, pull_en, rd_data;
  gbs_net_type net_state = GBS_OFF;
  int miscompares = 0, check_count = 0, ones;
  always #4 clk = ~clk;
  localparam int ON_T  = 4;
  localparam int OFF_T = 8;
  gbs_gpio_bank #(.ON_CYC(ON_T), .OFF_CYC(OFF_T)) dut_u (.clk, .nrst, .clk_en, .pad_i(pad_w), .cfg_dir_wr, .cfg_dir,
    .cfg_alt_wr, .cfg_alt, .wr_en, .wr_mask, .wr_data, .rd_en, .net_state, .wake_evt, .pad_o, .pad_oe,
    .pull_en, .rd_data, .rd_valid, .alt_active);
  gbs_pad_model pads_u (.pad_o, .pad_oe, .pull_en, .ext_en, .ext_lvl, .pad_w);
  function automatic logic [NUM_PADS-1:0] exp_rd(input logic [NUM_PADS-1:0] d, w, e);
    return (d & w) | (~d & e);
  endfunction
  task automatic chk(input logic [NUM_PADS-1:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic count_led(input int n);
    ones = 0;
    repeat (n)
    begin
      step(1);
      ones += int'(pad_o[0]);
    end
  endtask
  task automatic conclude;
    if (miscompares == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    void'($urandom(32'h0833023a));
    step(5);
    nrst = 1'h1;
    chk(pull_en, 10'h3ff);
    chk(pad_oe, 10'h000);
    ext_en = 10'h3ff;
    repeat (30)
    begin
      cfg_dir = 10'($urandom);
      cfg_dir_wr = 10'h3ff;
      ext_lvl = 10'($urandom);
      step(1);
      cfg_dir_wr = 10'h0;
      wr_en = 1'h1;
      wr_mask = 10'h3ff;
      wr_data = 10'($urandom);
      step(1);
      wr_en = 1'h0;
      // The idle cycle lets the synchroniser see the pads under their new direction.
      step(1);
      rd_en = 1'h1;
      step(1);
      rd_en = 1'h0;
      chk(10'(rd_valid), 10'h001);
      chk(rd_data, exp_rd(cfg_dir, wr_data, ext_lvl));
      chk(pad_oe, cfg_dir);
    end
    ext_en = 10'h0;
    cfg_dir = 10'h0;
    cfg_dir_wr = 10'h3ff;
    step(1);
    cfg_dir_wr = 10'h0;
    step(2);
    rd_en = 1'h1;
    step(1);
    rd_en = 1'h0;
    chk(rd_data, 10'h0);
    cfg_alt = 1'h1;
    cfg_alt_wr = 1'h1;
    net_state = GBS_NOT_REG;
    step(1);
    cfg_alt_wr = 1'h0;
    wr_en = 1'h1;
    wr_mask = 10'h001;
    wr_data = 10'h0;
    step(1);
    wr_en = 1'h0;
    step(1);
    chk(pad_o & pad_oe, 10'h001);
    chk(pad_oe, 10'h001);
    chk(10'(alt_active), 10'h001);
    net_state = GBS_REG_IDLE;
    count_led(2 * (ON_T + OFF_T));
    chk(10'(ones), 10'(2 * ON_T));
    net_state = GBS_REG_PSM;
    count_led(20);
    chk(10'(ones), 10'h000);
    wake_evt = 1'h1;
    step(1);
    wake_evt = 1'h0;
    chk(pad_o & pad_oe, 10'h001);
    count_led(11);
    chk(10'(ones), 10'(ON_T - 1));
    net_state = GBS_OFF;
    step(2);
    chk(pad_o & pad_oe, 10'h000);
    net_state = GBS_CONNECTING;
    count_led(2 * (ON_T + OFF_T));
    chk(10'(ones), 10'(2 * ON_T));
    clk_en = 1'h0;
    cfg_dir = 10'h3ff;
    cfg_dir_wr = 10'h3ff;
    count_led(3);
    chk(pad_oe, 10'h001);
    chk(10'(ones), 10'h000);
    cfg_dir_wr = 10'h0;
    clk_en = 1'h1;
    nrst = 1'h0;
    step(2);
    nrst = 1'h1;
    chk(pull_en, 10'h3ff);
    chk(pad_oe | pad_o, 10'h000);
    chk(10'(alt_active), 10'h000);
    conclude();
  end
endmodule
